// >>> hdl/crb_state_request_status.sv
// State-request and state-status control of the command/response buffer interface
// Summary of operation
// - Without bypass, ready request moves Idle to Ready.
// - Ready request bit is cleared within the ready-transition timeout.
// - Writing 0 to either request bit changes nothing.
// - With bypass, ready request moves Command Completion straight to Ready.
// - Bypass support is shown in a read-only capability bit.
// - Idle request bit is cleared within the ready-transition timeout.
// - Accepted idle request invalidates buffer, enters Idle, sets idle flag.
// - A placed response is kept until software requests idle.
// - Idle request: invalidate buffer, status becomes 0002h, then request clears.
// - Request writes are discarded during Command Execution.
// - Status bits 31:2 read zero; status is read-only.
// - Idle flag reads 1 in Idle, cleared on move to Ready.
// - Status bit 0 shows a fatal error.
// - First buffer byte in Ready enters Command Reception until start.
// - Start in Command Reception enters Execution; elsewhere ignored.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module crb_state_request_status
    import crb_state_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_C_CYCLES,
    parameter int WAKE_CYCLES = READY_LATENCY,
    parameter logic IDLE_BYPASS = 1'b0
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regReadData,
    input wire logic bufferFirstWrite,
    input wire logic commandDone,
    input wire logic fatalErrorPin,
    output logic bufferInvalidate,
    output logic responseHold,
    output logic executeStart,
    output logic irq,
    output logic [2:0] stateOut
);
    crb_state_t state;
    logic readyRequest;
    logic idleRequest;
    logic idleFlag;
    logic fatalErrorFlag;
    logic startFlag;
    logic fatalSync;
    logic wakeLaunch;
    logic wakeDone;
    logic idleStep;
    logic [INT_W-1:0] intStatus;
    logic [INT_W-1:0] intMask;
    logic [INT_W-1:0] intEvent;

    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
        return addr == offset;
    endfunction : hit

    logic reqWrite;
    logic readyWrite1;
    logic idleWrite1;
    logic startWrite1;
    assign reqWrite = regWrite && hit(regAddr, REQ_OFFSET) && state != ST_EXECUTION;
    assign readyWrite1 = reqWrite && regWriteData[READY_BIT];
    assign idleWrite1 = reqWrite && regWriteData[IDLE_BIT];
    assign startWrite1 = regWrite && hit(regAddr, START_OFFSET) && regWriteData[START_BIT];

    sync_two_ff #(
        .WIDTH(1)
    ) u_fatal_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async(fatalErrorPin),
        .synced(fatalSync)
    );

    // Wake time checked to be at least 2 cycles below the timeout so acknowledges always land in time
    wake_delay #(
        .LATENCY(WAKE_CYCLES)
    ) u_wake (
        .clock(clock),
        .sys_rst(sys_rst),
        .launch(wakeLaunch),
        .abort(idleStep),
        .done(wakeDone)
    );

    initial begin
        if (WAKE_CYCLES + 2 > TIMEOUT_CYCLES) begin
            $error("wake time exceeds acknowledge timeout");
        end
    end

    // Wake starts when a ready request is accepted in Idle without bypass
    logic wakeBusy;
    assign wakeLaunch = readyRequest && !wakeBusy && state == ST_IDLE && !IDLE_BYPASS;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wakeBusy <= 1'b0;
        end else if (wakeDone || idleStep) begin
            wakeBusy <= 1'b0;
        end else if (wakeLaunch) begin
            wakeBusy <= 1'b1;
        end
    end

    // Idle step taken in the cycle the request bit is set, one cycle after the write
    assign idleStep = idleRequest && state != ST_EXECUTION;

    // Main state machine
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else if (idleStep) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (wakeDone) begin
                        state <= ST_READY;
                    end else if (IDLE_BYPASS && readyRequest) begin
                        state <= ST_READY;
                    end
                end
                ST_READY: begin
                    if (bufferFirstWrite) begin
                        state <= ST_RECEPTION;
                    end
                end
                ST_RECEPTION: begin
                    if (startWrite1) begin
                        state <= ST_EXECUTION;
                    end
                end
                ST_EXECUTION: begin
                    if (commandDone) begin
                        state <= ST_COMPLETION;
                    end
                end
                ST_COMPLETION: begin
                    if (IDLE_BYPASS && readyRequest) begin
                        state <= ST_READY;
                    end
                end
            endcase
        end
    end

    // Request register bits
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            readyRequest <= 1'b0;
        end else if (idleStep) begin
            readyRequest <= REQ_CLEAR_VALUE[READY_BIT];
        end else if (readyWrite1) begin
            readyRequest <= 1'b1;
        end else if (readyRequest) begin
            // Acknowledge once the move is done, or at once if nothing to do
            if (wakeDone || IDLE_BYPASS || (state != ST_IDLE && !wakeBusy)) begin
                readyRequest <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            idleRequest <= 1'b0;
        end else if (idleStep) begin
            idleRequest <= 1'b0;
        end else if (idleWrite1) begin
            idleRequest <= 1'b1;
        end
    end

    // Idle flag; written together with buffer invalidate, before request clears
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            idleFlag <= 1'b1;
        end else if (idleWrite1) begin
            idleFlag <= 1'b1;
        end else if (state == ST_IDLE && (wakeDone || (IDLE_BYPASS && readyRequest))) begin
            idleFlag <= 1'b0;
        end else if (state == ST_COMPLETION && IDLE_BYPASS && readyRequest) begin
            idleFlag <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fatalErrorFlag <= 1'b0;
        end else begin
            fatalErrorFlag <= fatalSync;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            startFlag <= 1'b0;
        end else if (state == ST_EXECUTION && commandDone) begin
            startFlag <= 1'b0;
        end else if (startWrite1 && state == ST_RECEPTION) begin
            startFlag <= 1'b1;
        end
    end

    // Buffer side effects
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bufferInvalidate <= 1'b0;
            responseHold <= 1'b0;
            executeStart <= 1'b0;
            stateOut <= 3'h0;
        end else begin
            bufferInvalidate <= idleWrite1;
            executeStart <= startWrite1 && state == ST_RECEPTION;
            stateOut <= state;
            if (idleStep) begin
                responseHold <= 1'b0;
            end else if (state == ST_EXECUTION && commandDone) begin
                responseHold <= 1'b1;
            end
        end
    end

    // Interrupt events: ready reached after wake (not on bypass), idle reached, command done
    assign intEvent[INT_READY] = readyRequest && !readyWrite1 && wakeDone;
    assign intEvent[INT_IDLE] = idleStep;
    assign intEvent[INT_DONE] = state == ST_EXECUTION && commandDone;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            intStatus <= '0;
        end else begin
            // Set wins over a same-cycle clear
            if (regWrite && hit(regAddr, INT_STATUS_OFFSET)) begin
                intStatus <= (intStatus & ~regWriteData[INT_W-1:0]) | intEvent;
            end else begin
                intStatus <= intStatus | intEvent;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            intMask <= '0;
        end else if (regWrite && hit(regAddr, INT_MASK_OFFSET)) begin
            intMask <= regWriteData[INT_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(intStatus & intMask);
        end
    end

    // Read port; status writes fall through with no effect
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            regReadData <= ZERO_WORD;
        end else if (regRead) begin
            regReadData <= ZERO_WORD;
            unique case (regAddr)
                REQ_OFFSET: begin
                    regReadData[READY_BIT] <= readyRequest;
                    regReadData[IDLE_BIT] <= idleRequest;
                end
                STATUS_OFFSET: begin
                    regReadData[IDLE_BIT] <= idleFlag;
                    regReadData[FATAL_BIT] <= fatalErrorFlag;
                end
                START_OFFSET: regReadData[START_BIT] <= startFlag;
                INTF_ID_OFFSET: regReadData[BYPASS_BIT] <= IDLE_BYPASS;
                INT_STATUS_OFFSET: regReadData[INT_W-1:0] <= intStatus;
                INT_MASK_OFFSET: regReadData[INT_W-1:0] <= intMask;
                default: regReadData <= ZERO_WORD;
            endcase
        end else begin
            regReadData <= ZERO_WORD;
        end
    end
endmodule : crb_state_request_status
`default_nettype wire

// >>> common/crb_state_pkg.sv
// Constants, register map and state encoding of the state-request block
package crb_state_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REQ_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
    localparam logic [ADDR_W-1:0] START_OFFSET = 4'h8;
    localparam logic [ADDR_W-1:0] INTF_ID_OFFSET = 4'hC;
    localparam logic [ADDR_W-1:0] INT_STATUS_OFFSET = 4'h1;
    localparam logic [ADDR_W-1:0] INT_MASK_OFFSET = 4'h2;
    localparam int READY_BIT = 0;
    localparam int IDLE_BIT = 1;
    localparam int FATAL_BIT = 0;
    localparam int BYPASS_BIT = 0;
    localparam int START_BIT = 0;
    localparam logic [31:0] STATUS_IDLE_VALUE = 32'h0000_0002;
    localparam logic [31:0] REQ_CLEAR_VALUE = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam int INT_W = 3;
    localparam int INT_READY = 0;
    localparam int INT_IDLE = 1;
    localparam int INT_DONE = 2;
    localparam int TIMEOUT_C_US = 200;
    localparam int CLOCK_MHZ = 100;
    localparam int TIMEOUT_C_CYCLES = TIMEOUT_C_US * CLOCK_MHZ;
    localparam int READY_LATENCY = 4;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READY,
        ST_RECEPTION,
        ST_EXECUTION,
        ST_COMPLETION
    } crb_state_t;
endpackage : crb_state_pkg

// >>> hdl/sync_two_ff.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stage <= '0;
            synced <= '0;
        end else begin
            stage <= async;
            synced <= stage;
        end
    end
endmodule : sync_two_ff
`default_nettype wire

// >>> hdl/wake_delay.sv
// Down-counter modelling the wake-up time from Idle to Ready
`timescale 1ns/100ps
`default_nettype none
module wake_delay #(
    parameter int LATENCY = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic launch,
    input wire logic abort,
    output logic done
);
    localparam int CW = $clog2(LATENCY + 1);
    logic [CW-1:0] count;
    logic running;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                running <= 1'b0;
            end else if (launch) begin
                count <= CW'(LATENCY);
                running <= 1'b1;
            end else if (running) begin
                if (count <= CW'(1)) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - CW'(1);
                end
            end
        end
    end
endmodule : wake_delay
`default_nettype wire

// >>> bench/crb_state_request_status_props.sv
// Assertion checker for the state-request and status block
`timescale 1ns/100ps
`default_nettype none
module crb_state_request_status_props
    import crb_state_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = 40
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regReadData,
    input wire logic bufferFirstWrite,
    input wire logic commandDone,
    input wire logic fatalErrorPin,
    input wire logic bufferInvalidate,
    input wire logic responseHold,
    input wire logic executeStart,
    input wire logic [2:0] stateOut
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic reqWr;
    logic statusRd;
    logic startWr;
    assign reqWr = regWrite && regAddr == REQ_OFFSET;
    assign statusRd = regRead && regAddr == STATUS_OFFSET;
    assign startWr = regWrite && regAddr == START_OFFSET && regWriteData[0];
    a_ready_from_idle: assert property (reqWr && regWriteData[1:0] == 2'b01 && stateOut == ST_IDLE
        |-> ##[1:TIMEOUT_CYCLES] stateOut == ST_READY) else $error("ready not reached");
    a_status_reserved_zero: assert property (statusRd |=> regReadData[31:2] == 30'h0)
        else $error("status reserved bits set");
    a_idle_flag_read: assert property (statusRd && stateOut == ST_IDLE ##1 stateOut == ST_IDLE
        |-> regReadData[1]) else $error("idle flag low in idle");
    a_fatal_flag_read: assert property ($stable(fatalErrorPin)[*4] ##0 statusRd
        |=> regReadData[0] == fatalErrorPin) else $error("fatal flag wrong");
    // State output lags the internal state by one cycle
    a_exec_holds_state: assert property (stateOut == ST_EXECUTION && !$past(commandDone)
        |=> stateOut == ST_EXECUTION) else $error("left execution early");
    a_start_ignored_elsewhere: assert property (startWr ##1 !(stateOut inside {ST_RECEPTION, ST_EXECUTION})
        |-> !executeStart ##1 stateOut != ST_EXECUTION) else $error("start not ignored");
    a_start_enters_exec: assert property (startWr ##1 stateOut == ST_RECEPTION
        |-> executeStart ##1 stateOut == ST_EXECUTION && !executeStart) else $error("start failed");
    a_idle_invalidates: assert property (reqWr && regWriteData[1]
        && stateOut inside {ST_READY, ST_RECEPTION, ST_COMPLETION}
        |=> bufferInvalidate ##2 stateOut == ST_IDLE) else $error("idle request failed");
    a_response_kept: assert property (responseHold && !(reqWr && regWriteData[1])
        && !$past(reqWr && regWriteData[1]) |=> responseHold) else $error("response dropped");
    a_reception_entry: assert property (bufferFirstWrite && !$past(regWrite) ##1 stateOut == ST_READY
        |=> stateOut == ST_RECEPTION) else $error("reception not entered");
endmodule : crb_state_request_status_props
bind crb_state_request_status crb_state_request_status_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
    .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .bufferFirstWrite(bufferFirstWrite), .commandDone(commandDone), .fatalErrorPin(fatalErrorPin),
    .bufferInvalidate(bufferInvalidate), .responseHold(responseHold), .executeStart(executeStart),
    .stateOut(stateOut));
`default_nettype wire

// >>> bench/crb_state_request_status_bench.sv
// Self-checking bench for the state-request and status block
`timescale 1ns/100ps
`default_nettype none
module crb_state_request_status_bench import crb_state_pkg::*;;
    localparam int TMO = 40;
    logic clock = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic bufferFirstWrite = 1'b0, commandDone = 1'b0, fatalErrorPin = 1'b0;
    logic [ADDR_W-1:0] regAddr = 4'h0;
    logic [31:0] regWriteData = 32'h0, regReadData, rdata;
    logic bufferInvalidate, responseHold, executeStart, irq;
    logic [2:0] stateOut;
    int mismatches = 0, testsRun = 0;
    // Software never takes the bypass here, so no double ready write
    crb_state_request_status #(.TIMEOUT_CYCLES(TMO), .WAKE_CYCLES(4), .IDLE_BYPASS(1'b0)) u_dut (
        .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
        .bufferFirstWrite(bufferFirstWrite), .commandDone(commandDone), .fatalErrorPin(fatalErrorPin),
        .bufferInvalidate(bufferInvalidate), .responseHold(responseHold), .executeStart(executeStart),
        .irq(irq), .stateOut(stateOut));
    initial begin
        forever #5 clock = ~clock;
    end
    task closeOut;
        $display("Comparisons %0d, mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : closeOut
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        rdata = regReadData;
    endtask : rd
    task evt(input logic done);
        @(posedge clock);
        commandDone <= done;
        bufferFirstWrite <= ~done;
        @(posedge clock);
        commandDone <= 1'b0;
        bufferFirstWrite <= 1'b0;
        #1;
    endtask : evt
    task st(input crb_state_t s);
        int i;
        i = 0;
        while (stateOut !== s && i < TMO) begin
            @(posedge clock);
            #1;
            i++;
        end
        chk("state", 32'(s), 32'(stateOut));
        if (stateOut !== s) closeOut();
    endtask : st
    // Polls the request word; software gives up after the timeout
    task reqClear;
        int i;
        i = 0;
        rd(REQ_OFFSET);
        while (rdata !== ZERO_WORD && i < TMO) begin
            rd(REQ_OFFSET);
            i++;
        end
        chk("request", REQ_CLEAR_VALUE, rdata);
        if (rdata !== ZERO_WORD) closeOut();
    endtask : reqClear
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        closeOut();
    end
    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        rd(STATUS_OFFSET);
        chk("status", STATUS_IDLE_VALUE, rdata);
        rd(INTF_ID_OFFSET);
        chk("bypass", 32'h0, {31'h0, rdata[BYPASS_BIT]});
        rd(4'h3);
        chk("unmapped", ZERO_WORD, rdata);
        wr(STATUS_OFFSET, 32'hFFFF_FFFF);
        rd(STATUS_OFFSET);
        chk("status ro", STATUS_IDLE_VALUE, rdata);
        wr(REQ_OFFSET, 32'h0);
        repeat (TMO) @(posedge clock);
        #1;
        chk("state", 32'(ST_IDLE), 32'(stateOut));
        wr(INT_MASK_OFFSET, 32'h7);
        wr(REQ_OFFSET, 32'h1);
        st(ST_READY);
        reqClear();
        rd(STATUS_OFFSET);
        chk("status", ZERO_WORD, rdata);
        rd(INT_STATUS_OFFSET);
        chk("int ready", 32'h1, {31'h0, rdata[INT_READY]});
        chk("irq", 32'h1, {31'h0, irq});
        wr(INT_MASK_OFFSET, 32'h0);
        repeat (2) @(posedge clock);
        #1;
        chk("irq", 32'h0, {31'h0, irq});
        wr(INT_STATUS_OFFSET, 32'h7);
        wr(INT_MASK_OFFSET, 32'h7);
        repeat (2) @(posedge clock);
        #1;
        chk("irq", 32'h0, {31'h0, irq});
        wr(START_OFFSET, 32'h1);
        repeat (2) @(posedge clock);
        #1;
        chk("state", 32'(ST_READY), 32'(stateOut));
        evt(1'b0);
        st(ST_RECEPTION);
        wr(START_OFFSET, 32'h1);
        chk("start", 32'h1, {31'h0, executeStart});
        wr(REQ_OFFSET, 32'h2);
        rd(REQ_OFFSET);
        chk("request", ZERO_WORD, rdata);
        st(ST_EXECUTION);
        evt(1'b1);
        st(ST_COMPLETION);
        chk("hold", 32'h1, {31'h0, responseHold});
        wr(REQ_OFFSET, 32'h2);
        chk("invalidate", 32'h1, {31'h0, bufferInvalidate});
        st(ST_IDLE);
        rd(STATUS_OFFSET);
        chk("status", STATUS_IDLE_VALUE, rdata);
        reqClear();
        chk("hold", 32'h0, {31'h0, responseHold});
        wr(REQ_OFFSET, 32'h1);
        st(ST_READY);
        evt(1'b0);
        st(ST_RECEPTION);
        wr(REQ_OFFSET, 32'h2);
        st(ST_IDLE);
        @(posedge clock);
        fatalErrorPin <= 1'b1;
        repeat (4) @(posedge clock);
        rd(STATUS_OFFSET);
        chk("status", STATUS_IDLE_VALUE | 32'h1, rdata);
        closeOut();
    end
endmodule : crb_state_request_status_bench
`default_nettype wire
